/* File: hdl/ormre_pkg.sv */
/*
 * Shared constants for the OR/move/rotate execution block: register
 * offsets, command field layout, operation codes and reset values.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ormre_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_STACK_TOP = 8'h10;
  localparam logic [7:0] OFS_FILE_ADDR = 8'h14;
  localparam logic [7:0] OFS_FILE_DATA = 8'h18;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_IMM_LSB = 12;

  // Status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_GIE = 2;
  localparam int ST_BAD_CMD = 3;

  // Widths of the architectural state
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int FILE_DEPTH = 128;

  // Values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] STACK_RST = 13'h0000;
  localparam logic [6:0] FADDR_RST = 7'h00;

  // Bits of a command word that no operation ever uses
  localparam logic [31:0] CMD_SPARE_MASK = 32'hFFF0_0800;

  // Operation codes
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_OR_IMMEDIATE_INTO_ACC = 3'h1,
    OP_LOAD_IMMEDIATE_INTO_ACC = 3'h2,
    OP_OR_ACC_WITH_FILE = 3'h3,
    OP_STORE_ACC_TO_FILE = 3'h4,
    OP_MOVE_FILE_VALUE = 3'h5,
    OP_INTERRUPT_RETURN = 3'h6,
    OP_ROTATE_LEFT_THRU_CARRY = 3'h7
  } ormre_op_e;

  // Bus-side state of the register slave
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RD_FETCH = 3'b010,
    BUS_RD_DONE = 3'b100
  } ormre_bus_e;

endpackage

/* File: hdl/ormre_exec.sv */
/*
 * Execution unit for OR, immediate load, accumulator/file moves, no-op,
 * interrupt return and rotate-left through carry, with its accumulator,
 * file registers, flags, program counter and return-stack top.
 * Assumes one AHB-Lite master, single word transfers, one clock domain.
 */
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// (RQ1) OR immediate into accumulator, set zero flag
// (RQ2) Load immediate, flags kept, spare bits zero
// (RQ3) OR accumulator with file, chosen target, zero
// (RQ4) Store accumulator to file, flags kept
// (RQ5) Move file value to accumulator or itself
// (RQ6) Move updates zero flag for either target
// (RQ7) Rotate file left through carry, carry only
// (RQ8) Interrupt return loads counter, sets enable
module ormre_exec import ormre_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [DATA_W-1:0] acc;
  logic carry;
  logic zero;
  logic global_irq_enable;
  logic bad_cmd;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] stack_top;
  logic [FADDR_W-1:0] file_addr;
  ormre_bus_e bus_state;
  ormre_bus_e next_bus_state;
  logic [7:0] dph_addr;
  logic dph_write;
  logic dph_read;
  logic addr_take;

  // Command being executed, sliced out of the write data
  ormre_op_e cmd_op;
  logic cmd_dest;
  logic [FADDR_W-1:0] cmd_faddr;
  logic [DATA_W-1:0] cmd_imm;
  logic cmd_fire;
  logic cmd_legal;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] or_res;
  logic [DATA_W-1:0] rot_res;
  logic wr_status;
  logic wr_file_data;

  // Spare bits a command must leave clear
  function automatic logic [31:0] spare_mask(input ormre_op_e op);
    logic [31:0] m;
    m = CMD_SPARE_MASK;
    case (op)
      OP_NOP, OP_INTERRUPT_RETURN: begin
        m = ~32'h0000_0007;
      end
      OP_OR_IMMEDIATE_INTO_ACC, OP_LOAD_IMMEDIATE_INTO_ACC: begin
        m = CMD_SPARE_MASK | 32'h0000_07F8;
      end
      OP_STORE_ACC_TO_FILE: begin
        m = CMD_SPARE_MASK | 32'h000F_F008;
      end
      default: begin
        m = CMD_SPARE_MASK | 32'h000F_F000;
      end
    endcase
    return m;
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == 8'h00;
  endfunction

  // Address phase is taken only when the bus is ready
  assign addr_take = hsel & hready & htrans[1];
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_addr <= 8'h00;
      dph_write <= 1'b0;
      dph_read <= 1'b0;
    end else if (hready) begin
      dph_addr <= haddr[7:0];
      dph_write <= addr_take & hwrite;
      dph_read <= addr_take & ~hwrite;
    end
  end

  // Reads get one wait state so hrdata can come from a flop
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (addr_take && !hwrite) begin
          next_bus_state = BUS_RD_FETCH;
        end
      end
      BUS_RD_FETCH: begin
        next_bus_state = BUS_RD_DONE;
      end
      BUS_RD_DONE: begin
        if (addr_take && !hwrite) begin
          next_bus_state = BUS_RD_FETCH;
        end else begin
          next_bus_state = BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  assign hreadyout = (bus_state != BUS_RD_FETCH);

  // Read mux; unmapped offsets read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == BUS_RD_FETCH) begin
      hrdata <= 32'h0000_0000;
      case (dph_addr)
        OFS_ACC: hrdata[7:0] <= acc;
        OFS_STATUS: begin
          hrdata[ST_CARRY] <= carry;
          hrdata[ST_ZERO] <= zero;
          hrdata[ST_GIE] <= global_irq_enable;
          hrdata[ST_BAD_CMD] <= bad_cmd;
        end
        OFS_PC: hrdata[12:0] <= pc;
        OFS_STACK_TOP: hrdata[12:0] <= stack_top;
        OFS_FILE_ADDR: hrdata[6:0] <= file_addr;
        OFS_FILE_DATA: hrdata[7:0] <= file_mem[file_addr];
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command decode straight from the write data phase
  assign cmd_op = ormre_op_e'(hwdata[CMD_OP_LSB +: 3]);
  assign cmd_dest = hwdata[CMD_DEST_BIT];
  assign cmd_faddr = hwdata[CMD_ADDR_LSB +: FADDR_W];
  assign cmd_imm = hwdata[CMD_IMM_LSB +: DATA_W];
  assign cmd_fire = dph_write && (dph_addr == OFS_CMD);
  assign cmd_legal = (hwdata & spare_mask(cmd_op)) == 32'h0000_0000; // [RQ2]
  assign fval = file_mem[cmd_faddr];
  assign or_res = acc | ((cmd_op == OP_OR_ACC_WITH_FILE) ? fval : cmd_imm);
  assign rot_res = {fval[6:0], carry}; // [RQ7]
  assign wr_status = dph_write && (dph_addr == OFS_STATUS);
  assign wr_file_data = dph_write && (dph_addr == OFS_FILE_DATA);

  // Accumulator: software write or instruction result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= ACC_RST;
    end else if (dph_write && dph_addr == OFS_ACC) begin
      acc <= hwdata[7:0];
    end else if (cmd_fire && cmd_legal) begin
      // Immediate ops and the store carry no target bit; file OR, move and rotate honour it
      case (cmd_op)
        OP_OR_IMMEDIATE_INTO_ACC: acc <= or_res; // [RQ1]
        OP_LOAD_IMMEDIATE_INTO_ACC: acc <= cmd_imm; // [RQ2]
        OP_OR_ACC_WITH_FILE: begin
          if (!cmd_dest) begin
            acc <= or_res; // [RQ3]
          end
        end
        OP_MOVE_FILE_VALUE: begin
          if (!cmd_dest) begin
            acc <= fval; // [RQ5]
          end
        end
        OP_ROTATE_LEFT_THRU_CARRY: begin
          if (!cmd_dest) begin
            acc <= rot_res; // [RQ7]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // File registers; no reset, contents are undefined at power-up
  always_ff @(posedge hclk) begin
    if (wr_file_data) begin
      file_mem[file_addr] <= hwdata[7:0];
    end else if (cmd_fire && cmd_legal) begin
      case (cmd_op)
        OP_STORE_ACC_TO_FILE: file_mem[cmd_faddr] <= acc; // [RQ4]
        OP_OR_ACC_WITH_FILE: begin
          if (cmd_dest) begin
            file_mem[cmd_faddr] <= or_res; // [RQ3]
          end
        end
        OP_MOVE_FILE_VALUE: begin
          if (cmd_dest) begin
            file_mem[cmd_faddr] <= fval; // [RQ5]
          end
        end
        OP_ROTATE_LEFT_THRU_CARRY: begin
          if (cmd_dest) begin
            file_mem[cmd_faddr] <= rot_res; // [RQ7]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Zero flag; only OR and move touch it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero <= 1'b0;
    end else if (wr_status) begin
      zero <= hwdata[ST_ZERO];
    end else if (cmd_fire && cmd_legal) begin
      case (cmd_op)
        OP_OR_IMMEDIATE_INTO_ACC: zero <= is_zero(or_res); // [RQ1]
        OP_OR_ACC_WITH_FILE: zero <= is_zero(or_res); // [RQ3]
        OP_MOVE_FILE_VALUE: zero <= is_zero(fval); // [RQ6]
        default: zero <= zero;
      endcase
    end
  end

  // Carry flag; only the rotate touches it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry <= 1'b0;
    end else if (wr_status) begin
      carry <= hwdata[ST_CARRY];
    end else if (cmd_fire && cmd_legal &&
                 cmd_op == OP_ROTATE_LEFT_THRU_CARRY) begin
      carry <= fval[7]; // [RQ7]
    end
  end

  // Global interrupt enable; set by interrupt return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_irq_enable <= 1'b0;
    end else if (wr_status) begin
      global_irq_enable <= hwdata[ST_GIE];
    end else if (cmd_fire && cmd_legal &&
                 cmd_op == OP_INTERRUPT_RETURN) begin
      global_irq_enable <= 1'b1; // [RQ8]
    end
  end

  // Refused command flag; set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bad_cmd <= 1'b0;
    end else if (cmd_fire && !cmd_legal) begin
      bad_cmd <= 1'b1; // [RQ2]
    end else if (wr_status && hwdata[ST_BAD_CMD]) begin
      bad_cmd <= 1'b0;
    end
  end

  // Program counter: steps per instruction, jumps on return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= PC_RST;
    end else if (cmd_fire && cmd_legal) begin
      if (cmd_op == OP_INTERRUPT_RETURN) begin
        pc <= stack_top; // [RQ8]
      end else begin
        pc <= pc + 13'h0001; // No-op only advances the counter [RQ8]
      end
    end
  end

  // Software-loaded stack top and file access pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_top <= STACK_RST;
      file_addr <= FADDR_RST;
    end else if (dph_write && dph_addr == OFS_STACK_TOP) begin
      stack_top <= hwdata[12:0];
    end else if (dph_write && dph_addr == OFS_FILE_ADDR) begin
      file_addr <= hwdata[6:0];
    end
  end

  // hsize is not checked: only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, haddr[31:8], dph_read};

endmodule

/* File: bench/ormre_monitor.sv */
/*
 * Port checker for the execution block's register slave.
 * Assumes one clock, async active-low reset, hready tied to hreadyout.
 */
`timescale 1ns/1ps
module ormre_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  logic taken;
  logic rd_q;
  logic [7:0] aq;

  // Address phase accepted at this edge
  assign taken = hsel & hready & htrans[1];

  // Read wait-cycle marker and the register it targets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      aq <= 8'h00;
    end else begin
      rd_q <= taken & !hwrite;
      if (taken) begin
        aq <= haddr[7:0];
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("read wait");
  property p_wr; taken && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write wait");
  property p_cmd; rd_q && aq == 8'h00 |=> hrdata == 32'h0000_0000; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd read");
  property p_acc; rd_q && aq == 8'h04 |=> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_acc: assert property (p_acc) else $error("acc width");
  property p_pc; rd_q && aq == 8'h0C |=> hrdata[31:13] == 19'h0_0000;
  endproperty
  a_pc: assert property (p_pc) else $error("pc width");
  property p_file; rd_q && aq == 8'h18 |=> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_file: assert property (p_file) else $error("file width");
  property p_hold; !rd_q |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");

  c_rd: cover property (taken && !hwrite);
  c_wr: cover property (taken && hwrite);
  c_file: cover property (rd_q && aq == 8'h18);
endmodule

/* File: bench/ormre_prog_mem.sv */
/*
 * Program memory model: the instruction words the bench executes.
 * Assumes op[2:0], dest[3], file[10:4], immediate[19:12].
 */
`timescale 1ns/1ps
module ormre_prog_mem (
  output logic [31:0] prog [15]
);
  // Spare bits zero except word 2, kept bad to provoke a refusal
  assign prog = '{32'h0005_A002, 32'h000A_5001, 32'h0000_0802,
    32'h0000_0002, 32'h0000_0001, 32'h0000_F002, 32'h0000_07FB,
    32'h0000_0104, 32'h0000_07F5, 32'h0000_020D, 32'h0000_07FF,
    32'h0000_0207, 32'h0000_0006, 32'h0000_0000, 32'h0000_07F3};
endmodule

/* File: bench/testbench.sv */
/*
 * Self-checking bench: AHB-Lite master running each instruction word
 * and reading back accumulator, status, counter and file registers.
 * Assumes the program-memory model and the port checker.
 */
`timescale 1ns/1ps
module testbench import ormre_pkg::*; ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic [31:0] prog [15];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  ormre_exec i_ormre_exec (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  ormre_prog_mem i_ormre_prog_mem (.prog(prog));

  // 100 MHz clock
  initial begin
    forever #5 hclk = ~hclk;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One single transfer; waits out any slave wait state
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask

  task automatic fset(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b1, OFS_FILE_ADDR, {25'h000_0000, a});
    xfer(1'b1, OFS_FILE_DATA, {24'h00_0000, d});
  endtask

  // Run one word, then check accumulator, flags and counter
  task automatic step(input int k, input logic [7:0] acc,
                      input logic [3:0] st, input logic [12:0] pc);
    xfer(1'b1, OFS_CMD, prog[k]);
    rchk(OFS_ACC, {24'h00_0000, acc});
    rchk(OFS_STATUS, {28'h000_0000, st});
    rchk(OFS_PC, {19'h0_0000, pc});
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rchk(OFS_ACC, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_0000);
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rchk(8'h1C, 32'h0000_0000);
    step(0, 8'h5A, 4'h0, 13'h0001);
    step(1, 8'hFF, 4'h0, 13'h0002);
    step(2, 8'hFF, 4'h8, 13'h0002);
    xfer(1'b1, OFS_STATUS, 32'h0000_0008);
    step(3, 8'h00, 4'h0, 13'h0003);
    step(4, 8'h00, 4'h2, 13'h0004);
    step(5, 8'h0F, 4'h2, 13'h0005);
    fset(7'h7F, 8'h30);
    step(6, 8'h0F, 4'h0, 13'h0006);
    rchk(OFS_FILE_DATA, 32'h0000_003F);
    step(7, 8'h0F, 4'h0, 13'h0007);
    xfer(1'b1, OFS_FILE_ADDR, 32'h0000_0010);
    rchk(OFS_FILE_DATA, 32'h0000_000F);
    step(8, 8'h3F, 4'h0, 13'h0008);
    fset(7'h20, 8'h00);
    step(9, 8'h3F, 4'h2, 13'h0009);
    rchk(OFS_FILE_DATA, 32'h0000_0000);
    xfer(1'b1, OFS_STATUS, 32'h0000_0003);
    fset(7'h7F, 8'h3F);
    step(10, 8'h3F, 4'h2, 13'h000A);
    rchk(OFS_FILE_DATA, 32'h0000_007F);
    fset(7'h20, 8'h80);
    step(11, 8'h00, 4'h3, 13'h000B);
    rchk(OFS_FILE_DATA, 32'h0000_0080);
    xfer(1'b1, OFS_STACK_TOP, 32'h0000_1ABC);
    step(12, 8'h00, 4'h7, 13'h1ABC);
    step(13, 8'h00, 4'h7, 13'h1ABD);
    step(14, 8'h7F, 4'h5, 13'h1ABE);
    tally_and_finish();
  end
endmodule

bind ormre_exec ormre_monitor i_ormre_monitor (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata));
